// ===== temp_target_defines.vh
// Purpose: Shared constants of the two-wire temperature sensor target.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only; no logic lives here.
`ifndef TEMP_TARGET_DEFINES_VH
`define TEMP_TARGET_DEFINES_VH

// Reset values of the result word and the pointer select bits.
`define TEMP_RESET       12'h000
`define PTR_RESET        2'h0

// Pointer code of the temperature result register.
`define PTR_TEMP         2'h0

// Fixed upper nibble of the binary address group.
`define ADDR_BINARY_BASE 4'h9

// Resolution codes and the masks that clear unused low bits.
`define RES_9BIT         2'h0
`define RES_10BIT        2'h1
`define RES_11BIT        2'h2
`define MASK_9BIT        12'hFF8
`define MASK_10BIT       12'hFFC
`define MASK_11BIT       12'hFFE
`define MASK_12BIT       12'hFFF

// Bus clock limits, in kHz, and the core clock rate.
`define SCL_FAST_MAX_KHZ 400
`define SCL_HS_MAX_KHZ   2000
`define CORE_CLK_KHZ     100000
// Core cycles in half a fastest bus clock period, rounded down.
`define SCL_HALF_CYCLES  ((`CORE_CLK_KHZ / `SCL_HS_MAX_KHZ) / 2)

`endif

// ===== addr_select_decode.v
// Purpose: Turns the address-select pin levels into a 7-bit target address.
// Assumes: Inputs are already synchronised; float flags come from pad sensing.
// Notes:   With THREE_LEVEL at 0 the float flags are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "temp_target_defines.vh"

module addr_select_decode
#(
    parameter THREE_LEVEL = 1
)
(
    // Pin levels, bit 2 is pin 2.
    input  wire [2:0] pin_level,
    // Pin left floating, bit 2 is pin 2.
    input  wire [2:0] pin_float,
    // Decoded address.
    output reg  [6:0] addr
);

    wire [2:0] flt;

    assign flt = (THREE_LEVEL != 0) ? pin_float : 3'h0;

    // Each float pattern selects its own address group.
    always @*
    begin
        case (flt)
            3'h0: addr = {`ADDR_BINARY_BASE, pin_level};
            3'h4:
            begin
                case (pin_level[1:0])
                    2'h0:    addr = 7'h70;
                    2'h1:    addr = 7'h72;
                    2'h2:    addr = 7'h73;
                    default: addr = 7'h75;
                endcase
            end
            3'h5:    addr = pin_level[1] ? 7'h74 : 7'h71;
            3'h6:    addr = pin_level[0] ? 7'h77 : 7'h76;
            3'h2:    addr = {5'h0A, pin_level[2], pin_level[0]};
            3'h1:    addr = {5'h0B, pin_level[2], pin_level[1]};
            3'h3:    addr = pin_level[2] ? 7'h36 : 7'h35;
            default: addr = 7'h37;
        endcase
    end

endmodule
`default_nettype wire

// ===== temp_sensor_two_wire_target.v
// Purpose: Two-wire target of a temperature sensor with pointer and result.
// Assumes: CORE_CLK is far faster than the bus clock; bus pins are async.
// Notes:   Registers other than the result word live outside this block.
//
// Contract
// - Read-only 12-bit result holds latest conversion.
// - Result read as two bytes, low nibble zero.
// - Two's complement, 0.0625 degree steps.
// - Result reads zero until first conversion.
// - Resolution 9 to 12 bits selectable.
// - Lower resolutions zero the unused low bits.
// - Device is target only, never drives clock.
// - Bus clock up to 400 kHz or 2 MHz.
// - Bytes travel most significant bit first.
// - Address byte then direction; ack on ninth clock.
// - Eight clocks plus ack; data stable clock-high.
// - Three-level pins decode to 27 addresses.
// - Binary variant answers 1001 plus pin bits.
// - Pins sampled at reset, start, acquire request.
// - First write byte loads the pointer.
// - Reads use last written pointer, kept.
// - Register sent high byte first, then low.
// - Acknowledge address, pointer and each data byte.
// - Two pointer bits select, reset to 00.
// - Controller acks read bytes, may end with NACK.
`timescale 1ns/1ps
`default_nettype none
`include "temp_target_defines.vh"

module temp_sensor_two_wire_target
#(
    parameter THREE_LEVEL = 1
)
(
    // Clock and reset.
    input  wire        CORE_CLK,
    input  wire        RST_N,
    // Bus clock, input only.
    input  wire        SCL,
    // Open-drain data line.
    input  wire        SDA_IN,
    output wire        SDA_OUT,
    output reg         SDA_OE,
    // Address-select pins and their float sense.
    input  wire        ADDR_SELECT_PIN_0,
    input  wire        ADDR_SELECT_PIN_1,
    input  wire        ADDR_SELECT_PIN_2,
    input  wire        ADDR_SELECT_FLOAT_0,
    input  wire        ADDR_SELECT_FLOAT_1,
    input  wire        ADDR_SELECT_FLOAT_2,
    input  wire        ADDR_ACQUIRE,
    // Converter side, same clock domain.
    input  wire [11:0] TEMP_RESULT,
    input  wire        TEMP_DONE,
    input  wire [1:0]  RESOLUTION,
    // Other registers of the device.
    input  wire [15:0] RD_WORD,
    output reg  [1:0]  POINTER_SELECT_BITS,
    output reg  [7:0]  WR_DATA,
    output reg         WR_STROBE,
    // Status.
    output reg  [6:0]  TARGET_ADDR,
    output reg         BUSY
);

    // Link states.
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RX   = 3'h1;
    localparam [2:0] ST_ACK  = 3'h2;
    localparam [2:0] ST_TX   = 3'h3;
    localparam [2:0] ST_MACK = 3'h4;

    // Which byte of a write is being received.
    localparam [1:0] KIND_ADDR = 2'h0;
    localparam [1:0] KIND_PTR  = 2'h1;
    localparam [1:0] KIND_DATA = 2'h2;

    reg  [1:0]  scl_s_q;
    reg  [1:0]  sda_s_q;
    reg         scl_q;
    reg         sda_q;
    reg  [5:0]  pin_s1_q;
    reg  [5:0]  pin_s2_q;
    reg  [2:0]  boot_q;
    reg  [2:0]  state_q;
    reg  [1:0]  kind_q;
    reg  [3:0]  bit_cnt_q;
    reg  [7:0]  shift_q;
    reg         read_q;
    reg         low_byte_q;
    reg         mack_q;
    reg  [11:0] temp_q;
    reg  [11:0] res_mask;
    wire [6:0]  decoded_addr;
    wire [15:0] read_word;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_det;
    wire        stop_det;
    wire        sample_pins;

    // The device never drives the clock, and pulls data only low.
    assign SDA_OUT = 1'b0;

    // Two flip-flops before anything reads a bus or pin level; the
    // fastest bus clock still gives dozens of core cycles per phase.
    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scl_s_q  <= 2'h3;
            sda_s_q  <= 2'h3;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
        end
        else
        begin
            scl_s_q  <= {scl_s_q[0], SCL};
            sda_s_q  <= {sda_s_q[0], SDA_IN};
            scl_q    <= scl_s_q[1];
            sda_q    <= sda_s_q[1];
            pin_s1_q <= {ADDR_SELECT_FLOAT_2, ADDR_SELECT_FLOAT_1,
                         ADDR_SELECT_FLOAT_0, ADDR_SELECT_PIN_2,
                         ADDR_SELECT_PIN_1, ADDR_SELECT_PIN_0};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Edges and bus conditions seen on the synchronised levels.
    assign scl_rise  = scl_s_q[1] & ~scl_q;
    assign scl_fall  = ~scl_s_q[1] & scl_q;
    assign start_det = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    assign stop_det  = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

    addr_select_decode
    #(
        .THREE_LEVEL (THREE_LEVEL)
    )
    u_decode
    (
        .pin_level (pin_s2_q[2:0]),
        .pin_float (pin_s2_q[5:3]),
        .addr      (decoded_addr)
    );

    // Pins are caught once after reset, at each START and on request;
    // the latch avoids re-sensing the pads on every byte. The boot sample
    // waits for the pin sync to fill, or it would latch reset values.
    assign sample_pins = boot_q[0] | start_det | ADDR_ACQUIRE;

    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            boot_q      <= 3'h4;
            TARGET_ADDR <= 7'h00;
        end
        else
        begin
            boot_q <= {1'b0, boot_q[2:1]};
            if (sample_pins)
            begin
                TARGET_ADDR <= decoded_addr;
            end
        end
    end

    // Mask of the bits kept at the chosen resolution.
    always @*
    begin
        case (RESOLUTION)
            `RES_9BIT:  res_mask = `MASK_9BIT;
            `RES_10BIT: res_mask = `MASK_10BIT;
            `RES_11BIT: res_mask = `MASK_11BIT;
            default:    res_mask = `MASK_12BIT;
        endcase
    end

    // Result register: zero until a conversion lands, then the latest
    // two's complement value with unused low bits cleared.
    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            temp_q <= `TEMP_RESET;
        end
        else if (TEMP_DONE)
        begin
            temp_q <= TEMP_RESULT & res_mask;
        end
    end

    // Word returned for the current pointer.
    assign read_word = (POINTER_SELECT_BITS == `PTR_TEMP) ?
                       {temp_q, 4'h0} : RD_WORD;

    // Byte engine. START and STOP win over any byte in progress, so a
    // controller may end a transfer at any bit.
    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_q             <= ST_IDLE;
            kind_q              <= KIND_ADDR;
            bit_cnt_q           <= 4'h0;
            shift_q             <= 8'h00;
            read_q              <= 1'b0;
            low_byte_q          <= 1'b0;
            mack_q              <= 1'b0;
            SDA_OE              <= 1'b0;
            POINTER_SELECT_BITS <= `PTR_RESET;
            WR_DATA             <= 8'h00;
            WR_STROBE           <= 1'b0;
            BUSY                <= 1'b0;
        end
        else
        begin
            WR_STROBE <= 1'b0;
            if (start_det)
            begin
                // Also a repeated START ending a write.
                state_q   <= ST_RX;
                kind_q    <= KIND_ADDR;
                bit_cnt_q <= 4'h0;
                SDA_OE    <= 1'b0;
                BUSY      <= 1'b1;
            end
            else if (stop_det)
            begin
                state_q <= ST_IDLE;
                SDA_OE  <= 1'b0;
                BUSY    <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ST_RX:
                    begin
                        if (scl_rise && bit_cnt_q != 4'h8)
                        begin
                            // Sampled on the rising edge, first bit is MSB.
                            shift_q   <= {shift_q[6:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_q == 4'h8)
                        begin
                            state_q <= ST_ACK;
                            SDA_OE  <= 1'b1;
                            case (kind_q)
                                KIND_ADDR:
                                begin
                                    read_q     <= shift_q[0];
                                    low_byte_q <= 1'b0;
                                    if (shift_q[7:1] != TARGET_ADDR)
                                    begin
                                        // Not ours: stay off the line.
                                        state_q <= ST_IDLE;
                                        SDA_OE  <= 1'b0;
                                        BUSY    <= 1'b0;
                                    end
                                end
                                KIND_PTR:
                                begin
                                    // Only the two low pointer bits count.
                                    POINTER_SELECT_BITS <= shift_q[1:0];
                                end
                                default:
                                begin
                                    WR_DATA   <= shift_q;
                                    WR_STROBE <= 1'b1;
                                end
                            endcase
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (kind_q == KIND_ADDR && read_q)
                            begin
                                // High byte goes out first.
                                state_q <= ST_TX;
                                shift_q <= read_word[15:8];
                                SDA_OE  <= ~read_word[15];
                            end
                            else
                            begin
                                state_q <= ST_RX;
                                SDA_OE  <= 1'b0;
                                kind_q  <= (kind_q == KIND_ADDR) ? KIND_PTR
                                                                 : KIND_DATA;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_q == 4'h7)
                            begin
                                // Release for the controller's ack bit.
                                state_q <= ST_MACK;
                                SDA_OE  <= 1'b0;
                            end
                            else
                            begin
                                shift_q   <= {shift_q[6:0], 1'b0};
                                SDA_OE    <= ~shift_q[6];
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                        begin
                            mack_q <= ~sda_q;
                        end
                        else if (scl_fall)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (mack_q)
                            begin
                                // Alternate high and low byte while acked.
                                state_q    <= ST_TX;
                                low_byte_q <= ~low_byte_q;
                                shift_q    <= low_byte_q ? read_word[15:8]
                                                         : read_word[7:0];
                                SDA_OE     <= low_byte_q ? ~read_word[15]
                                                         : ~read_word[7];
                            end
                            else
                            begin
                                // NACK ends the read; wait for STOP or START.
                                state_q <= ST_IDLE;
                                BUSY    <= 1'b0;
                            end
                        end
                    end
                    default:
                    begin
                        SDA_OE <= 1'b0;
                    end
                endcase
            end
        end
    end

    // The controller owns clock, START and STOP; nothing here drives them.

endmodule
`default_nettype wire

// ===== two_wire_target_properties.sv
// Purpose: Bus-side timing checks of the two-wire temperature target.
// Assumes: Bound to the target top; one clock domain.
// Notes:   Only design outputs are judged, against their input causes.
`timescale 1ns/1ps
`default_nettype none
module two_wire_target_checker
#(
    parameter THREE_LEVEL = 1
)
(
    // Clock, reset and bus.
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    input wire logic       SCL,
    input wire logic       SDA_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE,
    // Address sense.
    input wire logic       ADDR_SELECT_FLOAT_0,
    input wire logic       ADDR_SELECT_FLOAT_1,
    input wire logic       ADDR_SELECT_FLOAT_2,
    // Register side and status.
    input wire logic [1:0] POINTER_SELECT_BITS,
    input wire logic       WR_STROBE,
    input wire logic [6:0] TARGET_ADDR,
    input wire logic       BUSY
);
    // Every check runs on the core clock and sleeps in reset.
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    property p_open_drain;
        SDA_OUT == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven high");
    // A data change with the clock high would read as START or STOP.
    property p_oe_scl_low;
        $changed(SDA_OE) |-> !SCL && !$past(SCL);
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data line moved while clock high");
    property p_ack_hold;
        $rose(SDA_OE) |=> SDA_OE [*5];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("pull-down dropped too soon");
    property p_oe_frame;
        SDA_OE |-> BUSY;
    endproperty
    a_oe_frame: assert property (p_oe_frame)
        else $error("data line pulled outside a frame");
    property p_strobe;
        WR_STROBE |-> BUSY ##1 !WR_STROBE;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("write strobe not a single pulse in a frame");
    property p_ptr_busy;
        $changed(POINTER_SELECT_BITS) |-> BUSY && $past(BUSY);
    endproperty
    a_ptr_busy: assert property (p_ptr_busy)
        else $error("pointer moved outside a write");
    property p_start;
        $rose(BUSY) |-> SCL && !SDA_IN;
    endproperty
    a_start: assert property (p_start)
        else $error("frame opened without a start");
    property p_addr_lock;
        BUSY && $past(BUSY) |-> $stable(TARGET_ADDR);
    endproperty
    a_addr_lock: assert property (p_addr_lock)
        else $error("own address changed inside a frame");
    property p_bin_addr;
        $rose(BUSY) && (THREE_LEVEL == 0 || !(ADDR_SELECT_FLOAT_0 || ADDR_SELECT_FLOAT_1
            || ADDR_SELECT_FLOAT_2)) |-> ##2 TARGET_ADDR[6:3] == 4'h9;
    endproperty
    a_bin_addr: assert property (p_bin_addr)
        else $error("binary pins left the binary group");
endmodule
`default_nettype wire

// ===== bus_ctl_model.sv
// Purpose: Behavioural two-wire bus controller that frames transfers.
// Assumes: Phases are counted in core cycles, changed at rising edges.
// Notes:   The clock stands high between frames; data is open drain.
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model
(
    // Pacing clock and wired data level.
    input  wire logic clk,
    input  wire logic sda,
    // Bus clock and data pull-down.
    output var  logic scl,
    output var  logic sda_low
);
    // Two core cycles a quarter give an 80 ns bus period; the target's
    // three-cycle release still lands inside each four-cycle low phase.
    localparam int Q = 2;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One phase: set both lines, then wait n quarters.
    task automatic ph(input logic s, input logic d, input int n);
        scl <= s;
        sda_low <= d;
        repeat (n * Q) @(posedge clk);
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start_c();
        ph(scl, 1'b0, 1);
        ph(1'b1, 1'b0, 2);
        ph(1'b1, 1'b1, 2);
        ph(1'b0, 1'b1, 1);
    endtask

    // Stop: data rises while the clock is high, then the bus idles.
    task automatic stop_c();
        ph(1'b0, 1'b1, 1);
        ph(1'b1, 1'b1, 2);
        ph(1'b1, 1'b0, 2);
    endtask

    // One bit: data set in the low phase, held and sampled while high.
    task automatic bitx(input logic b, output logic r);
        ph(1'b0, !b, 1);
        ph(1'b1, !b, 2);
        r = sda;
        ph(1'b0, !b, 1);
    endtask

    // Eight bits most significant first, then the acknowledge slot.
    task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] q,
                         output logic ao);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(ai, ao);
    endtask
endmodule
`default_nettype wire

// ===== temp_sensor_two_wire_target_test.sv
// Purpose: Self-checking bench of the two-wire temperature target.
// Assumes: The bus model paces bits from the core clock.
// Notes:   Bus period is 8 core cycles, 80 ns; the sync keeps up with one cycle to spare.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_two_wire_target_test;
    logic        clk, rst_n, scl, m_low, acq, tdone, wr_stb, busy, sda_oe, sda_out, ack;
    logic [2:0]  pins, flt;
    logic [11:0] tres, mdl_t;
    logic [1:0]  res, ptr;
    logic [15:0] rd_word, w;
    logic [7:0]  wr_data, q;
    logic [6:0]  taddr;
    logic [12:0] e;
    wire         sda = !(m_low || sda_oe);
    int          n_errors = 0, cmp_count = 0, nstb = 0, r;
    int unsigned rs = 15455;
    // Float entries: float flags, pin levels, expected address.
    logic [12:0] tab [5] = '{{6'o40, 7'h70}, {6'o20, 7'h28}, {6'o30, 7'h35},
                             {6'o70, 7'h37}, {6'o16, 7'h2F}};

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    temp_sensor_two_wire_target uut (
        .CORE_CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .ADDR_SELECT_PIN_0(pins[0]), .ADDR_SELECT_PIN_1(pins[1]),
        .ADDR_SELECT_PIN_2(pins[2]), .ADDR_SELECT_FLOAT_0(flt[0]),
        .ADDR_SELECT_FLOAT_1(flt[1]), .ADDR_SELECT_FLOAT_2(flt[2]), .ADDR_ACQUIRE(acq),
        .TEMP_RESULT(tres), .TEMP_DONE(tdone), .RESOLUTION(res), .RD_WORD(rd_word),
        .POINTER_SELECT_BITS(ptr), .WR_DATA(wr_data), .WR_STROBE(wr_stb),
        .TARGET_ADDR(taddr), .BUSY(busy));
    bus_ctl_model ctl (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

    // Counts write pulses so a lost or doubled byte shows up.
    always @(posedge clk)
        if (wr_stb === 1'b1)
            nstb <= nstb + 1;

    function automatic int unsigned rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        cmp_count++;
        if (g !== x)
        begin
            $display("BAD %s expected %h seen %h", n, x, g);
            n_errors++;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_ptr(input logic [6:0] a, input logic [7:0] p, input logic stop);
        ctl.start_c();
        ctl.xbyte({a, 1'b0}, 1'b1, q, ack);
        chk("write address ack", 16'h0000, {15'h0, ack});
        ctl.xbyte(p, 1'b1, q, ack);
        chk("pointer ack", 16'h0000, {15'h0, ack});
        if (stop)
            ctl.stop_c();
    endtask

    task automatic rd(input logic [6:0] a);
        ctl.start_c();
        ctl.xbyte({a, 1'b1}, 1'b1, q, ack);
        chk("read address ack", 16'h0000, {15'h0, ack});
        ctl.xbyte(8'hFF, 1'b0, w[15:8], ack);
        ctl.xbyte(8'hFF, 1'b1, w[7:0], ack);
        ctl.stop_c();
    endtask

    // The longest run is near 5700 cycles; this leaves ample margin.
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        rst_n = 1'b0;
        {pins, flt, acq, tdone, res, tres, rd_word} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_word <= 16'(rnd());
        repeat (8) @(posedge clk);
        chk("pointer at reset", 16'h0000, {14'h0, ptr});
        rd(7'h48);
        chk("result before conversion", 16'h0000, w);
        // Each resolution, starting with one small positive and one small negative value.
        for (int i = 0; i < 8; i++)
        begin
            r = (3 - i) & 3;
            res <= 2'(r);
            tres <= (i == 0) ? 12'h004 : (i == 1) ? 12'hFFC : 12'(rnd());
            tdone <= 1'b1;
            @(posedge clk);
            tdone <= 1'b0;
            mdl_t = tres & (12'hFFF << (3 - r));
            rd(7'h48);
            chk("result", {mdl_t, 4'h0}, w);
        end
        wr_ptr(7'h48, 8'hFD, 1'b1);
        chk("pointer", 16'h0001, {14'h0, ptr});
        repeat (2)
        begin
            rd(7'h48);
            chk("pointed word", rd_word, w);
        end
        // Back to the result, two data bytes, then a repeated start.
        wr_ptr(7'h48, 8'h00, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            ctl.xbyte(8'hA5 ^ 8'(i), 1'b1, q, ack);
            chk("data ack", 16'h0000, {15'h0, ack});
        end
        chk("write count", 16'h0002, 16'(nstb));
        chk("write data", 16'h00A4, {8'h00, wr_data});
        rd(7'h48);
        chk("result after write", {mdl_t, 4'h0}, w);
        ctl.start_c();
        ctl.xbyte({7'h49, 1'b0}, 1'b1, q, ack);
        ctl.stop_c();
        chk("miss ack", 16'h0001, {15'h0, ack});
        chk("busy after miss", 16'h0000, {15'h0, busy});
        // Every binary pin pattern, then the float table.
        for (int k = 0; k < 13; k++)
        begin
            e = (k < 8) ? {3'h0, 3'(k), 4'h9, 3'(k)} : tab[k - 8];
            {flt, pins} <= e[12:7];
            repeat (4) @(posedge clk);
            acq <= 1'b1;
            @(posedge clk);
            acq <= 1'b0;
            repeat (3) @(posedge clk);
            chk("own address", {9'h0, e[6:0]}, {9'h0, taddr});
            wr_ptr(e[6:0], 8'h00, 1'b1);
        end
        end_of_test();
    end
endmodule

bind temp_sensor_two_wire_target two_wire_target_checker #(.THREE_LEVEL(THREE_LEVEL)) prop_i (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .ADDR_SELECT_FLOAT_0(ADDR_SELECT_FLOAT_0),
    .ADDR_SELECT_FLOAT_1(ADDR_SELECT_FLOAT_1), .ADDR_SELECT_FLOAT_2(ADDR_SELECT_FLOAT_2),
    .POINTER_SELECT_BITS(POINTER_SELECT_BITS), .WR_STROBE(WR_STROBE),
    .TARGET_ADDR(TARGET_ADDR), .BUSY(BUSY));
`default_nettype wire
